// >>> psc_pkg.sv
package psc_pkg;

    // Stored control fields, bit positions within a control register
    localparam int unsigned BIT_EL0_EN = 0;
    localparam int unsigned BIT_EL1_EN = 1;
    localparam int unsigned BIT_CX = 3;
    localparam int unsigned BIT_PA = 4;
    localparam int unsigned BIT_TS = 5;
    localparam int unsigned BIT_PCT = 6;
    localparam int unsigned CTRL_W = 7;
    localparam int unsigned DATA_W = 64;

    // Bits that hold state; bits 63:7 and 2 are reserved zero
    localparam logic [6:0] CTRL_WR_MASK = 7'h7B;

    // Reset values of both control registers
    localparam logic [6:0] LEVEL1_RESET = 7'h00;
    localparam logic [6:0] LEVEL2_RESET = 7'h00;

    // Buffer-owner encodings
    localparam logic [1:0] OWNER_EL1 = 2'h0;
    localparam logic [1:0] SEC_OWNER_SECURE = 2'h1;
    localparam logic [1:0] SEC_OWNER_NONSECURE = 2'h3;

    // Privilege levels
    localparam logic [1:0] LVL0 = 2'h0;
    localparam logic [1:0] LVL1 = 2'h1;
    localparam logic [1:0] LVL2 = 2'h2;
    localparam logic [1:0] LVL3 = 2'h3;

    // Register name used by the move instruction
    typedef enum logic [1:0] {
        PSC_NAME_LEVEL1 = 2'h0,
        PSC_NAME_ALIAS = 2'h1,
        PSC_NAME_LEVEL2 = 2'h2
    } psc_name_e;

    // Outcome of an access, one-hot
    typedef enum logic [3:0] {
        PSC_RES_OK = 4'h1,
        PSC_RES_UNDEF = 4'h2,
        PSC_RES_TRAP_EL2 = 4'h4,
        PSC_RES_TRAP_EL3 = 4'h8
    } psc_result_e;

endpackage

// >>> psc_sample_control.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Level-1 bit 1 enables level-1 sampling, bit 0 enables level-0 sampling.
// - Level-1 sampling enables ignored when non-secure with trap-general-exceptions set.
// - Level-1 bit 3 collects context id; ignored at level 2 or non-secure trapping.
// - Bit 4 collects physical addresses; combined with level-2 bit when non-secure and owner nonzero.
// - Bit 5 enables timestamps; level-1 copy ignored non-secure with owner zero.
// - Bit 6 picks physical count; level-1 copy reads one without level 2.
// - Level-1 address and counter bits ignored non-secure owner zero; combined non-secure owner nonzero, alone in secure.
// - Bits 63:7 and bit 2 of both registers read as zero.
// - Level-1 register access from level 0 is undefined.
// - Non-secure level-1 access traps to level 2 when profiling trap set.
// - Secure level 1 traps unless owner 01; level 2 or non-secure unless 11.
// - With host extension, level-1 name at level 2 reaches level-2 register.
// - Alias undefined at levels 0-1, host extension off, or secure with level 3.
// - Level-2 access via alias or level-2 register traps unless owner 11.
// - Level-2 register access from level 1 or 0 is undefined.
// - Without level 2, level-2 register reads zero but acts as address/counter one.
// - Level-2 bits 6..3 ignored in secure; timestamp also ignored when owner nonzero.
// - Level-2 counter select combines with level-1 select when non-secure and owner nonzero.
// - Level-2 bit 1 enables level-2 sampling; zero when owner nonzero, secure ignored.
// - Level-2 bit 0 enables host level-0 sampling; ignored secure or trapping clear.
module psc_sample_control #(
    parameter bit HAS_LEVEL2 = 1'b1,
    parameter bit HAS_LEVEL3 = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Processor state
    input wire logic [1:0] cur_level,
    input wire logic secure_state_indicator,
    input wire logic trap_general_exceptions,
    input wire logic host_extension_control,
    input wire logic [1:0] buffer_owner_field,
    input wire logic level2_profiling_trap,
    input wire logic [1:0] secure_buffer_owner_field,
    // System register move request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_name,
    input wire logic [63:0] req_wdata,
    // Move response
    output logic rsp_valid,
    output logic [3:0] rsp_result,
    output logic [63:0] rsp_rdata,
    // Effective controls for the sampling logic
    output logic sampling_enabled,
    output logic timestamp_enable,
    output logic counter_select,
    output logic phys_addr_collect,
    output logic context_id1_collect,
    output logic context_id2_collect
);

    logic [6:0] level1_q;
    logic [6:0] level2_q;
    logic [6:0] next_level1;
    logic [6:0] next_level2;
    logic rsp_valid_q;
    logic [3:0] rsp_result_q;
    logic [63:0] rsp_rdata_q;
    logic next_rsp_valid;
    logic [3:0] next_rsp_result;
    logic [63:0] next_rsp_rdata;

    logic non_secure;
    logic owner_zero;
    logic tge_ns;
    logic [6:0] level1_view;
    logic [6:0] level2_view;
    logic [6:0] level2_act;
    logic hits_level1;
    logic hits_level2;
    logic [3:0] result;
    logic at_level0;
    logic at_level1;
    logic at_level2;
    logic below_level2;
    logic secure_level1;
    logic ns_level1;
    logic owner_is_secure;
    logic owner_is_nonsecure;
    logic trap_to_el2;
    logic secure_l1_trap;
    logic shared_trap;
    logic level2_trap;
    logic alias_undef;
    logic level1_name_redirect;
    logic level0_enable;
    logic level1_enable;
    logic level2_enable;

    // Level 3 always runs secure; below level 3 the state bit decides alone
    assign non_secure = secure_state_indicator && (cur_level != psc_pkg::LVL3);
    assign owner_zero = buffer_owner_field == psc_pkg::OWNER_EL1;
    assign tge_ns = non_secure && trap_general_exceptions;

    // Access qualifiers, decoded once and shared by all three register names
    assign at_level0 = cur_level == psc_pkg::LVL0;
    assign at_level1 = cur_level == psc_pkg::LVL1;
    assign at_level2 = cur_level == psc_pkg::LVL2;
    assign below_level2 = at_level0 || at_level1;
    assign secure_level1 = at_level1 && !non_secure;
    assign ns_level1 = at_level1 && non_secure;
    assign owner_is_secure = secure_buffer_owner_field == psc_pkg::SEC_OWNER_SECURE;
    assign owner_is_nonsecure = secure_buffer_owner_field == psc_pkg::SEC_OWNER_NONSECURE;
    assign trap_to_el2 = ns_level1 && level2_profiling_trap;
    // Level-3 traps need level 3 to exist at all
    assign secure_l1_trap = HAS_LEVEL3 && secure_level1 && !owner_is_secure;
    assign shared_trap = HAS_LEVEL3 && (at_level2 || ns_level1) && !owner_is_nonsecure;
    assign level2_trap = HAS_LEVEL3 && at_level2 && !owner_is_nonsecure;
    assign alias_undef = !HAS_LEVEL2 || below_level2 || !host_extension_control
        || (HAS_LEVEL3 && !secure_state_indicator);
    assign level1_name_redirect = at_level2 && host_extension_control;

    // Read views: reserved bits zero, level-1 counter bit forced without level 2
    always_comb begin
        level1_view = level1_q & psc_pkg::CTRL_WR_MASK;
        if (!HAS_LEVEL2) begin
            level1_view[psc_pkg::BIT_PCT] = 1'b1;
        end
    end

    // Stored enables kept while masked, so handing the buffer back restores them
    always_comb begin
        level2_view = level2_q & psc_pkg::CTRL_WR_MASK;
        if (!owner_zero) begin
            level2_view[psc_pkg::BIT_EL1_EN] = 1'b0;
            level2_view[psc_pkg::BIT_EL0_EN] = 1'b0;
        end
        if (!HAS_LEVEL2) begin
            level2_view = '0;
        end
    end

    // Value the sampling logic acts on, distinct from a direct read
    always_comb begin
        level2_act = level2_view;
        if (!HAS_LEVEL2) begin
            level2_act[psc_pkg::BIT_PA] = 1'b1;
            level2_act[psc_pkg::BIT_PCT] = 1'b1;
        end
    end

    // Access check: undefined first, then level-2 trap, then level-3 trap
    always_comb begin
        hits_level1 = 1'b0;
        hits_level2 = 1'b0;
        result = psc_pkg::PSC_RES_OK;
        case (psc_pkg::psc_name_e'(req_name))
            psc_pkg::PSC_NAME_LEVEL1: begin
                if (at_level0) begin
                    result = psc_pkg::PSC_RES_UNDEF;
                end else if (trap_to_el2) begin
                    result = psc_pkg::PSC_RES_TRAP_EL2;
                end else if (secure_l1_trap || shared_trap) begin
                    result = psc_pkg::PSC_RES_TRAP_EL3;
                end
                if (level1_name_redirect) begin
                    hits_level2 = 1'b1;
                end else begin
                    hits_level1 = 1'b1;
                end
            end

            psc_pkg::PSC_NAME_ALIAS: begin
                if (alias_undef) begin
                    result = psc_pkg::PSC_RES_UNDEF;
                end else if (level2_trap) begin
                    result = psc_pkg::PSC_RES_TRAP_EL3;
                end
                hits_level1 = 1'b1;
            end

            psc_pkg::PSC_NAME_LEVEL2: begin
                if (below_level2) begin
                    result = psc_pkg::PSC_RES_UNDEF;
                end else if (level2_trap) begin
                    result = psc_pkg::PSC_RES_TRAP_EL3;
                end
                hits_level2 = 1'b1;
            end

            default: begin
                result = psc_pkg::PSC_RES_UNDEF;
            end
        endcase
    end

    // Register update; refused accesses leave both registers alone
    always_comb begin
        next_level1 = level1_q;
        next_level2 = level2_q;
        if (req_valid && req_write && result == psc_pkg::PSC_RES_OK) begin
            if (hits_level1) begin
                next_level1 = req_wdata[6:0] & psc_pkg::CTRL_WR_MASK;
            end else if (hits_level2 && HAS_LEVEL2) begin
                // Writes dropped without level 2, the register is plain zero there
                next_level2 = req_wdata[6:0] & psc_pkg::CTRL_WR_MASK;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            level1_q <= psc_pkg::LEVEL1_RESET;
            level2_q <= psc_pkg::LEVEL2_RESET;
        end else begin
            level1_q <= next_level1;
            level2_q <= next_level2;
        end
    end

    // Response carries the value before a write; zero when refused
    always_comb begin
        next_rsp_valid = req_valid;
        next_rsp_result = psc_pkg::PSC_RES_OK;
        next_rsp_rdata = '0;
        if (req_valid) begin
            next_rsp_result = result;
            if (result == psc_pkg::PSC_RES_OK && hits_level1) begin
                next_rsp_rdata = {57'h0, level1_view};
            end else if (result == psc_pkg::PSC_RES_OK && hits_level2) begin
                next_rsp_rdata = {57'h0, level2_view};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rsp_valid_q <= 1'b0;
            rsp_result_q <= psc_pkg::PSC_RES_OK;
            rsp_rdata_q <= '0;
        end else begin
            rsp_valid_q <= next_rsp_valid;
            rsp_result_q <= next_rsp_result;
            rsp_rdata_q <= next_rsp_rdata;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_result = rsp_result_q;
    assign rsp_rdata = rsp_rdata_q;

    // Per-level enables; level 0 follows the host bit while traps go to level 2
    assign level0_enable = tge_ns ? level2_act[psc_pkg::BIT_EL0_EN]
        : level1_view[psc_pkg::BIT_EL0_EN];
    assign level1_enable = !tge_ns && level1_view[psc_pkg::BIT_EL1_EN];
    assign level2_enable = non_secure && level2_act[psc_pkg::BIT_EL1_EN];

    // Effective controls; combinational so a level change takes effect at once
    always_comb begin
        sampling_enabled = 1'b0;
        case (cur_level)
            psc_pkg::LVL0: begin
                sampling_enabled = level0_enable;
            end

            psc_pkg::LVL1: begin
                sampling_enabled = level1_enable;
            end

            psc_pkg::LVL2: begin
                sampling_enabled = level2_enable;
            end

            // Level 3 never samples
            default: begin
                sampling_enabled = 1'b0;
            end
        endcase
    end

    // Collection selects; combining is a plain AND until the exact rule is known
    always_comb begin
        if (!non_secure) begin
            // Secure: level-2 bits all ignored
            timestamp_enable = level1_view[psc_pkg::BIT_TS];
            phys_addr_collect = level1_view[psc_pkg::BIT_PA];
            counter_select = level1_view[psc_pkg::BIT_PCT];
            context_id2_collect = 1'b0;
        end else if (owner_zero) begin
            // Level-1 copies ignored, level 2 owns the buffer
            timestamp_enable = level2_act[psc_pkg::BIT_TS];
            phys_addr_collect = level2_act[psc_pkg::BIT_PA];
            counter_select = level2_act[psc_pkg::BIT_PCT];
            context_id2_collect = level2_act[psc_pkg::BIT_CX];
        end else begin
            timestamp_enable = level1_view[psc_pkg::BIT_TS];
            phys_addr_collect = level1_view[psc_pkg::BIT_PA] && level2_act[psc_pkg::BIT_PA];
            counter_select = level1_view[psc_pkg::BIT_PCT] && level2_act[psc_pkg::BIT_PCT];
            context_id2_collect = level2_act[psc_pkg::BIT_CX];
        end
        // Counter choice only matters while timestamps are taken
        counter_select = counter_select && timestamp_enable;
        context_id1_collect = level1_view[psc_pkg::BIT_CX] && cur_level != psc_pkg::LVL2 && !tge_ns;
    end

endmodule

// >>> psc_sample_control_monitor.sv
`timescale 1ns/10ps
module psc_sample_control_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Processor state
    input wire logic [1:0] cur_level,
    input wire logic secure_state_indicator,
    input wire logic level2_profiling_trap,
    input wire logic [1:0] secure_buffer_owner_field,
    // Move request and response
    input wire logic req_valid,
    input wire logic [1:0] req_name,
    input wire logic rsp_valid,
    input wire logic [3:0] rsp_result,
    input wire logic [63:0] rsp_rdata,
    // Effective controls
    input wire logic timestamp_enable,
    input wire logic counter_select,
    input wire logic context_id2_collect
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_answer; req_valid |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_res0; rsp_valid |-> rsp_rdata[63:7] == 57'h0 && !rsp_rdata[2]; endproperty
    a_res0: assert property (p_res0) else $error("reserved bits set");
    property p_refused; rsp_valid && rsp_result != psc_pkg::PSC_RES_OK |-> rsp_rdata == 64'h0; endproperty
    a_refused: assert property (p_refused) else $error("refused access leaks data");
    property p_el0; req_valid && cur_level == psc_pkg::LVL0 |=> rsp_result == psc_pkg::PSC_RES_UNDEF; endproperty
    a_el0: assert property (p_el0) else $error("level 0 access not undefined");
    property p_el1; req_valid && cur_level == psc_pkg::LVL1 && req_name == psc_pkg::PSC_NAME_LEVEL2
        |=> rsp_result == psc_pkg::PSC_RES_UNDEF; endproperty
    a_el1: assert property (p_el1) else $error("level 1 reached level-2 register");
    property p_trap2; req_valid && cur_level == psc_pkg::LVL1 && secure_state_indicator && level2_profiling_trap
        && req_name == psc_pkg::PSC_NAME_LEVEL1 |=> rsp_result == psc_pkg::PSC_RES_TRAP_EL2; endproperty
    a_trap2: assert property (p_trap2) else $error("missing trap to level 2");
    property p_trap3; req_valid && cur_level == psc_pkg::LVL1 && !secure_state_indicator
        && secure_buffer_owner_field != psc_pkg::SEC_OWNER_SECURE && req_name == psc_pkg::PSC_NAME_LEVEL1
        |=> rsp_result == psc_pkg::PSC_RES_TRAP_EL3; endproperty
    a_trap3: assert property (p_trap3) else $error("missing secure trap to level 3");
    property p_l2trap; req_valid && cur_level == psc_pkg::LVL2 && secure_state_indicator
        && secure_buffer_owner_field != psc_pkg::SEC_OWNER_NONSECURE && req_name == psc_pkg::PSC_NAME_LEVEL2
        |=> rsp_result == psc_pkg::PSC_RES_TRAP_EL3; endproperty
    a_l2trap: assert property (p_l2trap) else $error("missing level-2 trap to level 3");
    property p_cx2; !secure_state_indicator |-> !context_id2_collect; endproperty
    a_cx2: assert property (p_cx2) else $error("level-2 context collected in secure");
    property p_pct; !timestamp_enable |-> !counter_select; endproperty
    a_pct: assert property (p_pct) else $error("counter picked without timestamp");
endmodule
bind psc_sample_control psc_sample_control_monitor psc_sample_control_monitor_inst (.*);

// >>> tb_psc_sample_control.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_psc_sample_control;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] lvl = 2'h1, bo = 2'h0, sbo = 2'h3, rn = 2'h0;
    logic ns = 1'b1, tge = 1'b0, e2h = 1'b0, tpms = 1'b0, rv = 1'b0, rw = 1'b0;
    logic [63:0] wd = 64'h0;
    logic rsp_valid, sen, ts, cs, pa, cx1, cx2;
    logic [3:0] rsp_result;
    logic [63:0] rsp_rdata;
    int n_fail = 0, checked = 0, cycles = 0;
    always #5 mclk = ~mclk;
    psc_sample_control psc_sample_control_inst (.mclk(mclk), .srst(srst), .cur_level(lvl),
        .secure_state_indicator(ns), .trap_general_exceptions(tge), .host_extension_control(e2h),
        .buffer_owner_field(bo), .level2_profiling_trap(tpms), .secure_buffer_owner_field(sbo),
        .req_valid(rv), .req_write(rw), .req_name(rn), .req_wdata(wd), .rsp_valid(rsp_valid),
        .rsp_result(rsp_result), .rsp_rdata(rsp_rdata), .sampling_enabled(sen), .timestamp_enable(ts),
        .counter_select(cs), .phys_addr_collect(pa), .context_id1_collect(cx1), .context_id2_collect(cx2));
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One move, answer judged 1 ns after the edge that takes it
    task automatic acc(input logic [1:0] l, input logic n, input logic [1:0] nm, input logic w,
                       input logic [63:0] d, input logic [3:0] er, input logic [63:0] ed);
        @(posedge mclk);
        lvl <= l;
        ns <= n;
        rn <= nm;
        rw <= w;
        wd <= d;
        rv <= 1'b1;
        @(posedge mclk);
        rv <= 1'b0;
        #1;
        `CHK("rsp_valid", 1'b1, rsp_valid)
        `CHK("rsp_result", er, rsp_result)
        `CHK("rsp_rdata", ed, rsp_rdata)
    endtask
    task automatic s_store();
        acc(2'h1, 1'b1, 2'h0, 1'b0, 64'h0, 4'h1, 64'h0);
        acc(2'h1, 1'b1, 2'h0, 1'b1, 64'hFFFFFFFFFFFFFFFF, 4'h1, 64'h0);
        acc(2'h1, 1'b1, 2'h0, 1'b0, 64'h0, 4'h1, 64'h7B);
    endtask
    task automatic s_undef();
        for (int i = 0; i < 3; i++)
            acc(2'h0, 1'b1, i[1:0], 1'b0, 64'h0, 4'h2, 64'h0);
        acc(2'h1, 1'b1, 2'h2, 1'b0, 64'h0, 4'h2, 64'h0);
        acc(2'h1, 1'b1, 2'h1, 1'b0, 64'h0, 4'h2, 64'h0);
    endtask
    task automatic s_trap();
        tpms <= 1'b1;
        acc(2'h1, 1'b1, 2'h0, 1'b1, 64'h0, 4'h4, 64'h0);
        tpms <= 1'b0;
        sbo <= 2'h1;
        acc(2'h1, 1'b1, 2'h0, 1'b0, 64'h0, 4'h8, 64'h0);
        acc(2'h1, 1'b0, 2'h0, 1'b0, 64'h0, 4'h1, 64'h7B);
        sbo <= 2'h3;
        acc(2'h1, 1'b0, 2'h0, 1'b0, 64'h0, 4'h8, 64'h0);
    endtask
    task automatic s_level2();
        e2h <= 1'b1;
        acc(2'h2, 1'b1, 2'h0, 1'b1, 64'h3, 4'h1, 64'h0);
        acc(2'h2, 1'b1, 2'h2, 1'b0, 64'h0, 4'h1, 64'h3);
        acc(2'h2, 1'b1, 2'h1, 1'b0, 64'h0, 4'h1, 64'h7B);
        acc(2'h2, 1'b0, 2'h1, 1'b0, 64'h0, 4'h2, 64'h0);
        bo <= 2'h1;
        acc(2'h2, 1'b1, 2'h2, 1'b0, 64'h0, 4'h1, 64'h0);
        sbo <= 2'h1;
        acc(2'h2, 1'b1, 2'h2, 1'b0, 64'h0, 4'h8, 64'h0);
        e2h <= 1'b0;
        acc(2'h2, 1'b1, 2'h1, 1'b0, 64'h0, 4'h2, 64'h0);
    endtask
    // Secure level 1: level-1 bits act alone
    task automatic s_secure();
        acc(2'h1, 1'b0, 2'h0, 1'b0, 64'h0, 4'h1, 64'h7B);
        `CHK("sen", 1'b1, sen)
        `CHK("ts", 1'b1, ts)
        `CHK("cs", 1'b1, cs)
        `CHK("cx1", 1'b1, cx1)
        acc(2'h1, 1'b0, 2'h0, 1'b1, 64'h20, 4'h1, 64'h7B);
        `CHK("sen", 1'b0, sen)
        `CHK("cs", 1'b0, cs)
    endtask
    // Non-secure, owner nonzero: address and counter are combined
    task automatic s_shared();
        sbo <= 2'h3;
        acc(2'h1, 1'b1, 2'h0, 1'b1, 64'h72, 4'h1, 64'h20);
        `CHK("sen", 1'b1, sen)
        `CHK("ts", 1'b1, ts)
        `CHK("pa", 1'b0, pa)
        `CHK("cs", 1'b0, cs)
        tge <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("sen", 1'b0, sen)
    endtask
    // Non-secure, level 2 owns the buffer: level-2 copies decide
    task automatic s_owner();
        bo <= 2'h0;
        acc(2'h2, 1'b1, 2'h2, 1'b1, 64'h59, 4'h1, 64'h3);
        `CHK("sen", 1'b0, sen)
        `CHK("ts", 1'b0, ts)
        `CHK("pa", 1'b1, pa)
        `CHK("cs", 1'b0, cs)
        `CHK("cx2", 1'b1, cx2)
        acc(2'h0, 1'b1, 2'h0, 1'b0, 64'h0, 4'h2, 64'h0);
        `CHK("sen", 1'b1, sen)
        `CHK("cx1", 1'b0, cx1)
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        s_store();
        s_undef();
        s_trap();
        s_level2();
        s_secure();
        s_shared();
        s_owner();
        close_out();
    end
endmodule
